// *** rtl/mcsr_top.sv ***
// What this block does
// - Modem input change raises modem request
// - Each input needs its enable bit
// - Detected change sets change-register bit
// - Modem pins double as general-purpose I/O
// - Posted rx/tx request waits for host acknowledge; modem request only while an enabled change bit stays set
// - Three request outputs, three vectors
// - Hardware acknowledge cycle acknowledges request
// - Acknowledge register read starts service
// - Ack cycle: ack and strobe, no select
// - Status: own three plus shared lines
`timescale 1ns/100ps
`default_nettype none
module mcsr_top
  import mcsr_pkg::*;
#(
  parameter int NCH = NUM_CHAN,
  parameter int NMD = NUM_MODEM
)
(
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Modem pins and request sources
  input wire logic [NCH*NMD-1:0] modem_in,
  output logic [NCH*NMD-1:0] modem_out,
  input wire logic rx_req_src,
  input wire logic tx_req_src,
  input wire logic [2:0] shared_req_n,
  // Hardware acknowledge pins
  input wire logic ack_chain_in_n,
  input wire logic data_strobe_n,
  input wire logic chip_select_n,
  output logic ack_chain_out_n,
  output logic [7:0] ack_vector,
  output logic ack_vector_valid,
  // Request outputs
  output logic req_rx_n,
  output logic req_tx_n,
  output logic req_mdm_n,
  output logic irq
);
  localparam int NB = NCH * NMD;
  // Registers are one word each, so the pin count must fit 32 bits
  if (NB > 32 || NB < 1)
  begin : g_bad_width
    $error("modem input count must fit one register word");
  end

  // Synchronised inputs
  logic [NB-1:0] pin_sync;
  logic [NB-1:0] pin_prev;     // Previous sample for edge compare
  logic [2:0] ackpins_sync;    // ack, strobe, select
  logic [2:0] shared_sync;
  logic [1:0] src_sync;

  mcsr_sync2 #(.WIDTH(NB)) u_sync_pins
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(modem_in),
    .sync_out(pin_sync)
  );

  mcsr_sync2 #(.WIDTH(8)) u_sync_ctl
  (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({ack_chain_in_n, data_strobe_n, chip_select_n, shared_req_n, rx_req_src, tx_req_src}),
    .sync_out({ackpins_sync, shared_sync, src_sync})
  );

  // Software registers
  logic [NB-1:0] enable;
  logic [NB-1:0] opt_pos;
  logic [NB-1:0] opt_neg;
  logic [NB-1:0] change;
  logic [4:0] dev_id;
  logic [2:0] irq_stat;   // modem acknowledged, tx posted, modem change events
  logic [2:0] irq_mask;
  // Per-category service state
  mcsr_svc_t st_rx, st_tx, st_mdm;
  mcsr_req_t raw, post;
  logic hw_ack_prev;

  // AXI handshake state
  logic aw_held, w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_go, rd_go;
  logic [7:0] rd_addr;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr;

  // Change detection on synchronised samples
  logic [NB-1:0] rise, fall, hit;
  assign rise = pin_sync & ~pin_prev & opt_pos;
  assign fall = ~pin_sync & pin_prev & opt_neg;
  assign hit = rise | fall;

  // Acknowledge cycle: ack and strobe low, select high
  logic hw_ack;
  assign hw_ack = !ackpins_sync[2] && !ackpins_sync[1] && ackpins_sync[0];
  logic hw_ack_rise;
  assign hw_ack_rise = hw_ack && !hw_ack_prev;

  // Raw request conditions
  assign raw.rx = src_sync[1];
  assign raw.tx = src_sync[0];
  assign raw.mdm = |(change & enable);

  // Posted means waiting for an acknowledge
  assign post.rx = (st_rx == MCSR_POSTED);
  assign post.tx = (st_tx == MCSR_POSTED);
  assign post.mdm = (st_mdm == MCSR_POSTED);

  // Register read/write decode pulses
  logic rd_ack_rx, rd_ack_tx, rd_ack_mdm, svc_done;
  assign rd_ack_rx = rd_go && rd_addr == OFF_ACK_RX;
  assign rd_ack_tx = rd_go && rd_addr == OFF_ACK_TX;
  assign rd_ack_mdm = rd_go && rd_addr == OFF_ACK_MDM;
  assign svc_done = wr_go && aw_addr == OFF_SVC_DONE;

  // Hardware ack picks highest posted category: rx, tx, modem
  logic hw_rx, hw_tx, hw_mdm;
  assign hw_rx = hw_ack_rise && post.rx;
  assign hw_tx = hw_ack_rise && !post.rx && post.tx;
  assign hw_mdm = hw_ack_rise && !post.rx && !post.tx && post.mdm;

  // Next service state for one category
  function automatic mcsr_svc_t next_svc(mcsr_svc_t s, logic req, logic ack, logic done);
    mcsr_svc_t n;
    n = s;
    case (s)
      MCSR_IDLE: if (req) n = MCSR_POSTED;
      MCSR_POSTED: if (ack) n = MCSR_SERVICE;
      MCSR_SERVICE: if (done) n = MCSR_IDLE;
      default: n = MCSR_IDLE;
    endcase
    return n;
  endfunction : next_svc

  // Category state machines; a service context ends by the done write
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_rx <= MCSR_IDLE;
      st_tx <= MCSR_IDLE;
      st_mdm <= MCSR_IDLE;
      hw_ack_prev <= 1'b0;
    end
    else
    begin
      st_rx <= next_svc(st_rx, raw.rx, rd_ack_rx || hw_rx, svc_done && w_data[0]);
      st_tx <= next_svc(st_tx, raw.tx, rd_ack_tx || hw_tx, svc_done && w_data[1]);
      st_mdm <= next_svc(st_mdm, raw.mdm, rd_ack_mdm || hw_mdm, svc_done && w_data[2]);
      hw_ack_prev <= hw_ack;
    end
  end

  // Request outputs, one per category, active low
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_rx_n <= 1'b1;
      req_tx_n <= 1'b1;
      req_mdm_n <= 1'b1;
      irq <= 1'b0;
    end
    else
    begin
      req_rx_n <= !post.rx;
      req_tx_n <= !post.tx;
      req_mdm_n <= !(post.mdm && raw.mdm);
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Acknowledge answer: vector while the ack cycle lasts; chain passes on if none posted
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ack_vector <= 8'h00;
      ack_vector_valid <= 1'b0;
      ack_chain_out_n <= 1'b1;
    end
    else if (!hw_ack)
    begin
      ack_vector_valid <= 1'b0;
      ack_chain_out_n <= 1'b1;
    end
    else if (hw_rx)
    begin
      ack_vector <= {dev_id, VEC_RX};
      ack_vector_valid <= 1'b1;
    end
    else if (hw_tx)
    begin
      ack_vector <= {dev_id, VEC_TX};
      ack_vector_valid <= 1'b1;
    end
    else if (hw_mdm)
    begin
      ack_vector <= {dev_id, VEC_MDM};
      ack_vector_valid <= 1'b1;
    end
    else if (hw_ack_rise)
    begin
      // Nothing posted here: hand the cycle down the chain
      ack_chain_out_n <= 1'b0;
    end
  end

  // Sample history and change bits; hardware set wins over host clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_prev <= '0;
      change <= '0;
    end
    else
    begin
      pin_prev <= pin_sync;
      if (wr_go && aw_addr == OFF_CHANGE)
        change <= (change & w_data[NB-1:0]) | hit;
      else
        change <= change | hit;
    end
  end

  // Sticky event bits for the local interrupt line, W1C
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat <= '0;
    else if (wr_go && aw_addr == OFF_IRQ_STAT)
      irq_stat <= (irq_stat & ~w_data[2:0]) | {hw_mdm || rd_ack_mdm, post.tx && !req_tx_n, |hit};
    else
      irq_stat <= irq_stat | {hw_mdm || rd_ack_mdm, post.tx && !req_tx_n, |hit};
  end

  // Configuration registers; modem outputs are software-driven only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enable <= '0;
      opt_pos <= '0;
      opt_neg <= '0;
      dev_id <= RST_DEV_ID;
      irq_mask <= '0;
      modem_out <= '0;
    end
    else if (wr_go)
    begin
      case (aw_addr)
        OFF_ENABLE: enable <= w_data[NB-1:0];
        OFF_OPTION_POS: opt_pos <= w_data[NB-1:0];
        OFF_OPTION_NEG: opt_neg <= w_data[NB-1:0];
        OFF_VECTOR: dev_id <= w_data[7:3];
        OFF_IRQ_MASK: irq_mask <= w_data[2:0];
        OFF_PIN_OUT: modem_out <= w_data[NB-1:0];
        default: ;
      endcase
    end
  end

  // Write channel: take address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0; // Ready flops mirror the held flags
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        // Ready again as the response rises; no handshake can meet this edge
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr > OFF_PIN_IN || aw_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end


  // Read channel: one read in flight; ack-register reads return the vector
  logic [31:0] rmux;
  always_comb
  begin
    rmux = RST_ZERO;
    case (rd_addr)
      OFF_ENABLE: rmux[NB-1:0] = enable;
      OFF_OPTION_POS: rmux[NB-1:0] = opt_pos;
      OFF_OPTION_NEG: rmux[NB-1:0] = opt_neg;
      OFF_CHANGE: rmux[NB-1:0] = change;
      OFF_PENDING: rmux[5:0] = {~shared_sync, post.mdm, post.tx, post.rx};
      OFF_ACK_RX: rmux[7:0] = post.rx ? {dev_id, VEC_RX} : 8'h00;
      OFF_ACK_TX: rmux[7:0] = post.tx ? {dev_id, VEC_TX} : 8'h00;
      OFF_ACK_MDM: rmux[7:0] = post.mdm ? {dev_id, VEC_MDM} : 8'h00;
      OFF_VECTOR: rmux[7:0] = {dev_id, 3'h0};
      OFF_IRQ_STAT: rmux[2:0] = irq_stat;
      OFF_IRQ_MASK: rmux[2:0] = irq_mask;
      OFF_PIN_OUT: rmux[NB-1:0] = modem_out;
      OFF_PIN_IN: rmux[NB-1:0] = pin_sync;
      default: rmux = RST_ZERO;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rmux;
        s_axi_rresp <= (rd_addr > OFF_PIN_IN || rd_addr[1:0] != 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : mcsr_top
`default_nettype wire

// *** rtl/mcsr_pkg.sv ***
package mcsr_pkg;
  // Channel and modem input counts
  localparam int NUM_CHAN = 8;
  localparam int NUM_MODEM = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_ENABLE = 8'h00;     // request_enable_reg, modem-input enables
  localparam logic [7:0] OFF_OPTION_POS = 8'h04; // rising-edge detect options
  localparam logic [7:0] OFF_OPTION_NEG = 8'h08; // falling-edge detect options
  localparam logic [7:0] OFF_CHANGE = 8'h0c;     // modem change bits, write zero to clear
  localparam logic [7:0] OFF_PENDING = 8'h10;    // request_pending_status_reg
  localparam logic [7:0] OFF_ACK_RX = 8'h14;     // read acknowledges receive
  localparam logic [7:0] OFF_ACK_TX = 8'h18;     // read acknowledges transmit
  localparam logic [7:0] OFF_ACK_MDM = 8'h1c;    // read acknowledges modem
  localparam logic [7:0] OFF_SVC_DONE = 8'h20;   // write ends service context
  localparam logic [7:0] OFF_VECTOR = 8'h24;     // global_vector_reg
  localparam logic [7:0] OFF_IRQ_STAT = 8'h28;   // sticky event status, W1C
  localparam logic [7:0] OFF_IRQ_MASK = 8'h2c;   // event mask
  localparam logic [7:0] OFF_PIN_OUT = 8'h30;    // general-purpose modem outputs
  localparam logic [7:0] OFF_PIN_IN = 8'h34;     // synchronised modem inputs
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [4:0] RST_DEV_ID = 5'h00;     // arbitrary device id
  // Vector low bits per category
  localparam logic [2:0] VEC_RX = 3'h3;
  localparam logic [2:0] VEC_TX = 3'h2;
  localparam logic [2:0] VEC_MDM = 3'h1;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Service category state
  typedef enum logic [1:0]
  {
    MCSR_IDLE = 2'h0,
    MCSR_POSTED = 2'h1,
    MCSR_SERVICE = 2'h2
  } mcsr_svc_t;

  // Request trio carried together
  typedef struct packed
  {
    logic rx;
    logic tx;
    logic mdm;
  } mcsr_req_t;
endpackage : mcsr_pkg

// *** rtl/mcsr_sync2.sv ***
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for asynchronous pin inputs
module mcsr_sync2 #(
  parameter int WIDTH = 1
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta; // First stage, read only by the second

  // Two stages; metastability settles in the first
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : mcsr_sync2
`default_nettype wire

// *** test/mcsr_properties.sv ***
`timescale 1ns/100ps
`default_nettype none
// Watches request, acknowledge and bus ports of the block
module mcsr_properties
  import mcsr_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic ack_chain_in_n,
  input wire logic data_strobe_n,
  input wire logic chip_select_n,
  input wire logic ack_chain_out_n,
  input wire logic [7:0] ack_vector,
  input wire logic ack_vector_valid,
  input wire logic req_rx_n,
  input wire logic req_tx_n,
  input wire logic req_mdm_n
);
  int since_evt; // Cycles since a bus access or acknowledge pin
  int legal_cnt; // Cycles a legal acknowledge cycle has stood
  // Any access may end a request, so it opens a short window
  always_ff @(posedge aclk)
  begin
    if (!aresetn || (s_axi_arvalid && s_axi_arready) || (s_axi_awvalid && s_axi_awready) || !ack_chain_in_n)
      since_evt <= 0;
    else if (since_evt < 15)
      since_evt <= since_evt + 1;
  end
  // Counts only while acknowledge and strobe are low and select is high
  always_ff @(posedge aclk)
  begin
    if (!aresetn || ack_chain_in_n || data_strobe_n || !chip_select_n)
      legal_cnt <= 0;
    else if (legal_cnt < 15)
      legal_cnt <= legal_cnt + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence ar_take_s;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_take_s;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  rx_req_hold_a: assert property ($rose(req_rx_n) |-> since_evt < 8)
    else $error("receive request dropped without acknowledge");
  tx_req_hold_a: assert property ($rose(req_tx_n) |-> since_evt < 8)
    else $error("transmit request dropped without acknowledge");
  mdm_req_hold_a: assert property ($rose(req_mdm_n) |-> since_evt < 8)
    else $error("modem request dropped without acknowledge");
  ack_cause_a: assert property ($rose(ack_vector_valid) |-> legal_cnt >= 2)
    else $error("vector given without a legal acknowledge cycle");
  ack_prio_a: assert property ($rose(ack_vector_valid) && $past(!req_rx_n) |-> ack_vector[2:0] == VEC_RX)
    else $error("receive vector not given first");
  ack_excl_a: assert property (!(ack_vector_valid && !ack_chain_out_n))
    else $error("vector given and acknowledge passed on");
  rd_answer_a: assert property (ar_take_s |=> s_axi_rvalid)
    else $error("read answer late");
  wr_answer_a: assert property (wr_take_s |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
endmodule : mcsr_properties
`default_nettype wire

// *** test/mcsr_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// Host side: interrupt input and acknowledge-cycle driver
module mcsr_host_model
  import mcsr_pkg::*;
(
  input wire logic aclk,
  input wire logic req_rx_n,
  input wire logic req_tx_n,
  input wire logic req_mdm_n,
  input wire logic ack_vector_valid,
  input wire logic [7:0] ack_vector,
  input wire logic ack_chain_out_n,
  output logic ack_chain_in_n,
  output logic data_strobe_n,
  output logic chip_select_n,
  output logic host_int
);
  // Single input: a real OR gate, never a wired tie of the three
  assign host_int = !(req_rx_n && req_tx_n && req_mdm_n);
  // Pins idle high on their pull-ups
  initial
  begin
    ack_chain_in_n = 1'h1;
    data_strobe_n = 1'h1;
    chip_select_n = 1'h1;
  end
  // Only offered with the three separate levels, never with polling
  task automatic ack_cycle(input logic sel_n, output logic served, output logic [7:0] vec,
    output logic passed);
    served = 1'h0;
    passed = 1'h0;
    vec = 8'h00;
    @(posedge aclk);
    ack_chain_in_n <= 1'h0;
    data_strobe_n <= 1'h0;
    chip_select_n <= sel_n;
    for (int i = 0; i < 12 && !served; i++)
    begin
      @(negedge aclk);
      served = ack_vector_valid;
      vec = ack_vector;
      passed = passed || !ack_chain_out_n;
    end
    @(posedge aclk);
    ack_chain_in_n <= 1'h1;
    data_strobe_n <= 1'h1;
    chip_select_n <= 1'h1;
  endtask : ack_cycle
endmodule : mcsr_host_model
`default_nettype wire

// *** test/modem_change_service_requests_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module modem_change_service_requests_tb
  import mcsr_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, mdm_in = 32'h0, rd_d;
  logic rx_src = 1'h0, tx_src = 1'h0, got, pss;
  logic [2:0] shr_n = 3'h7;
  logic [1:0] rd_r, wr_r;
  logic [7:0] gvec;
  wire logic awready, wready, bvalid, arready, rvalid, rx_n, tx_n, mdm_n, irq;
  wire logic ack_in_n, ds_n, cs_n, out_n, vvalid, host_int;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata, mdm_out;
  wire logic [7:0] vec;
  int fails = 0, n_checks = 0, cycles = 0;
  always #25 aclk = ~aclk;
  mcsr_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .modem_in(mdm_in),
    .modem_out(mdm_out), .rx_req_src(rx_src), .tx_req_src(tx_src), .shared_req_n(shr_n),
    .ack_chain_in_n(ack_in_n), .data_strobe_n(ds_n), .chip_select_n(cs_n), .ack_chain_out_n(out_n),
    .ack_vector(vec), .ack_vector_valid(vvalid), .req_rx_n(rx_n), .req_tx_n(tx_n),
    .req_mdm_n(mdm_n), .irq(irq));
  mcsr_host_model host (.aclk(aclk), .req_rx_n(rx_n), .req_tx_n(tx_n), .req_mdm_n(mdm_n),
    .ack_vector_valid(vvalid), .ack_vector(vec), .ack_chain_out_n(out_n), .ack_chain_in_n(ack_in_n),
    .data_strobe_n(ds_n), .chip_select_n(cs_n), .host_int(host_int));
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // A hang counts as a mismatch
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fails++;
      tally_and_finish;
    end
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got_v);
    n_checks++;
    if (got_v !== exp)
      $display("[ERR] %s expected %h seen %h", nm, exp, got_v);
    if (got_v !== exp)
      fails++;
  endtask : chk
  // Handshakes are judged at the falling edge, where all is settled
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh, bh;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      @(posedge aclk);
      if (ah) awvalid <= 1'h0;
      if (wh) wvalid <= 1'h0;
    end while ((awvalid && !ah) || (wvalid && !wh));
    do
    begin
      @(negedge aclk);
      bh = bvalid;
      wr_r = bresp;
      @(posedge aclk);
    end while (!bh);
    bready <= 1'h0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
    logic ah, rh;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do
    begin
      @(negedge aclk);
      ah = arvalid && arready;
      @(posedge aclk);
      if (ah) arvalid <= 1'h0;
    end while (!ah);
    do
    begin
      @(negedge aclk);
      rh = rvalid;
      rd_d = rdata;
      rd_r = rresp;
      @(posedge aclk);
    end while (!rh);
    rready <= 1'h0;
    chk(nm, exp, rd_d);
  endtask : rdc
  // Waits a bounded time for request k (2 rx, 1 tx, 0 modem) to reach lvl
  task automatic waitreq(input int k, input logic lvl, input string nm);
    logic [2:0] r;
    for (int i = 0; i < 30; i++)
    begin
      @(negedge aclk);
      r = {rx_n, tx_n, mdm_n};
      if (r[k] === lvl) break;
    end
    chk(nm, 32'(lvl), 32'(r[k]));
  endtask : waitreq
  task automatic t_reset;
    rdc(OFF_ENABLE, RST_ZERO, "enable reset");
    rdc(OFF_CHANGE, RST_ZERO, "change reset");
    rdc(8'hfc, RST_ZERO, "unmapped data");
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(rd_r));
    wr(8'hfc, 32'h0);
    chk("unmapped wr resp", 32'(RESP_SLVERR), 32'(wr_r));
    chk("requests idle", 32'h7, {29'h0, rx_n, tx_n, mdm_n});
  endtask : t_reset
  task automatic t_modem;
    wr(OFF_OPTION_POS, 32'h30);
    chk("wr resp", 32'(RESP_OKAY), 32'(wr_r));
    wr(OFF_ENABLE, 32'h20);
    @(posedge aclk) mdm_in[4] <= 1'h1;
    repeat (12) @(posedge aclk);
    chk("disabled input", 32'h1, 32'(mdm_n));
    wr(OFF_CHANGE, 32'h0);
    @(posedge aclk) mdm_in[5] <= 1'h1;
    waitreq(0, 1'h0, "modem request");
    rdc(OFF_CHANGE, 32'h20, "change bit");
    @(posedge aclk) shr_n <= 3'h3;
    repeat (4) @(posedge aclk);
    rdc(OFF_PENDING, 32'h24, "pending");
    @(posedge aclk) shr_n <= 3'h7;
    repeat (10) @(posedge aclk);
    chk("modem held", 32'h0, 32'(mdm_n));
    rdc(OFF_ACK_MDM, {24'h0, RST_DEV_ID, VEC_MDM}, "modem vector");
    waitreq(0, 1'h1, "modem serviced");
    rdc(OFF_CHANGE, 32'h20, "change kept");
    wr(OFF_CHANGE, 32'h0);
    wr(OFF_SVC_DONE, 32'h4);
    @(posedge aclk) mdm_in[5] <= 1'h0;
    repeat (12) @(posedge aclk);
    chk("falling ignored", 32'h1, 32'(mdm_n));
    rdc(OFF_CHANGE, 32'h0, "change clear");
  endtask : t_modem
  task automatic t_hw_ack;
    @(posedge aclk) rx_src <= 1'h1;
    waitreq(2, 1'h0, "rx request");
    host.ack_cycle(1'h0, got, gvec, pss);
    chk("selected cycle", 32'h0, 32'(got));
    host.ack_cycle(1'h1, got, gvec, pss);
    chk("ack cycle", 32'h1, 32'(got));
    chk("served not passed", 32'h0, 32'(pss));
    chk("rx vector", {24'h0, RST_DEV_ID, VEC_RX}, {24'h0, gvec});
    @(posedge aclk) rx_src <= 1'h0;
    waitreq(2, 1'h1, "rx serviced");
    wr(OFF_SVC_DONE, 32'h1);
    host.ack_cycle(1'h1, got, gvec, pss);
    chk("idle not served", 32'h0, 32'(got));
    chk("idle passed on", 32'h1, 32'(pss));
  endtask : t_hw_ack
  task automatic t_tx_irq;
    @(posedge aclk) tx_src <= 1'h1;
    waitreq(1, 1'h0, "tx request");
    chk("or of requests", 32'h1, 32'(host_int));
    chk("irq masked", 32'h0, 32'(irq));
    wr(OFF_IRQ_MASK, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq raised", 32'h1, 32'(irq));
    rdc(OFF_PENDING, 32'h2, "pending tx");
    rdc(OFF_ACK_TX, {24'h0, RST_DEV_ID, VEC_TX}, "tx vector");
    @(posedge aclk) tx_src <= 1'h0;
    waitreq(1, 1'h1, "tx serviced");
    wr(OFF_IRQ_STAT, 32'h2);
    repeat (3) @(posedge aclk);
    chk("irq cleared", 32'h0, 32'(irq));
    wr(OFF_SVC_DONE, 32'h2);
    rdc(OFF_PENDING, 32'h0, "none left");
    chk("or idle", 32'h0, 32'(host_int));
  endtask : t_tx_irq
  task automatic t_pins;
    wr(OFF_PIN_OUT, 32'ha5a5_0f0f);
    @(posedge aclk) mdm_in <= 32'hffff_ffff;
    repeat (6) @(posedge aclk);
    chk("pins out", 32'ha5a5_0f0f, mdm_out);
    rdc(OFF_PIN_IN, 32'hffff_ffff, "pins in");
    waitreq(0, 1'h0, "pin change request");
    host.ack_cycle(1'h1, got, gvec, pss);
    chk("modem hw ack", 32'h1, 32'(got));
    chk("modem hw vector", {24'h0, RST_DEV_ID, VEC_MDM}, {24'h0, gvec});
  endtask : t_pins
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset;
    t_modem;
    t_hw_ack;
    t_tx_irq;
    t_pins;
    tally_and_finish;
  end
endmodule : modem_change_service_requests_tb
bind mcsr_top mcsr_properties chk_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ack_chain_in_n,
  .data_strobe_n, .chip_select_n, .ack_chain_out_n, .ack_vector, .ack_vector_valid, .req_rx_n,
  .req_tx_n, .req_mdm_n);
`default_nettype wire
